//--- ump_pkg.sv
// constants and types shared by the serial line channel and its fifo
`default_nettype none

package ump_pkg;

  // ----------------------------------------------------------------
  // data path sizes
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W     = 3;
  localparam logic [15:0] BAUD_DIV_DEF = 16'h0010;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_DATA       = 3'h0;
  localparam logic [2:0] OFF_INT_EN     = 3'h1;
  localparam logic [2:0] OFF_INT_STS    = 3'h2;
  localparam logic [2:0] OFF_FIFO_CTRL  = 3'h2;
  localparam logic [2:0] OFF_LINE_CTRL  = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFF_LINE_STS   = 3'h5;
  localparam logic [2:0] OFF_MODEM_STS  = 3'h6;
  localparam logic [2:0] OFF_INT_CLR    = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MC_TERM_READY = 0;
  localparam int MC_SEND_REQ   = 1;
  localparam int MC_INT_OUT    = 3;
  localparam int MC_LOOP       = 4;
  localparam int LC_STOP2      = 2;
  localparam int LC_PAR_EN     = 3;
  localparam int LC_PAR_EVEN   = 4;
  localparam int LC_TX_EN      = 6;
  localparam int FC_TRIG_LO    = 6;
  localparam int MS_CTS        = 4;
  localparam int MS_DSR        = 5;
  localparam int MS_RING       = 6;
  localparam int MS_CARRIER    = 7;
  localparam int LS_RX_AVAIL   = 0;
  localparam int LS_OVERRUN    = 1;
  localparam int LS_PARITY     = 2;
  localparam int LS_FRAMING    = 3;
  localparam int LS_TX_ROOM    = 5;
  localparam int LS_TX_IDLE    = 6;
  localparam int IS_RX_TRIG    = 0;
  localparam int IS_TX_EMPTY   = 1;
  localparam int IS_MODEM      = 2;
  localparam int IS_LINE_ERR   = 3;
  localparam int PIN_RXD       = 0;
  localparam int PIN_CTS       = 1;
  localparam int PIN_DSR       = 2;
  localparam int PIN_CD        = 3;
  localparam int PIN_RI        = 4;

  // ----------------------------------------------------------------
  // reset values and receive fill thresholds
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_CTRL_RST  = 8'h40;
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0] INT_EN_RST     = 8'h00;
  localparam logic [7:0] FIFO_CTRL_RST  = 8'h00;
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0e;
  localparam logic [3:0] DATA_BITS = 4'h8;

  // ----------------------------------------------------------------
  // state machine codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } ump_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } ump_rx_t;

endpackage

`default_nettype wire

//--- ump_fifo.sv
// byte fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module ump_fifo
  import ump_pkg::*;
#(
  parameter int W     = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [W-1:0]               inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [W-1:0]                    outData,
  output logic [$clog2(DEPTH+1)-1:0]      fillCount
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wrPtr;
    logic [PW-1:0]           rdPtr;
    logic [CW-1:0]           count;
  } ump_fifo_state_t;

  ump_fifo_state_t st_reg;
  ump_fifo_state_t st_next;
  logic            doPush;
  logic            doPop;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady   = (st_reg.count != CW'(DEPTH));
  assign outValid  = (st_reg.count != '0);
  assign outData   = st_reg.mem[st_reg.rdPtr];
  assign fillCount = st_reg.count;
  assign doPush    = inValid && inReady;
  assign doPop     = outValid && outReady;

  always_comb begin
    st_next = st_reg;
    if (doPush) begin
      st_next.mem[st_reg.wrPtr] = inData;
      st_next.wrPtr = nextPtr(st_reg.wrPtr);
    end
    if (doPop) begin
      st_next.rdPtr = nextPtr(st_reg.rdPtr);
    end
    if (doPush && !doPop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (doPop && !doPush) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

//--- ump_line_chan.sv
// one serial channel: framing, buffers, modem pins, registers, interrupt
//
// Overview of operation
// - Terminal-ready output goes low while modem control bit 0 is set, high when clear or after reset.
// - Send-request output goes low while modem control bit 1 is set and is high after reset.
// - A low-to-high transition of the ring input raises a modem-status interrupt event.
// - The clear-to-send level is readable in bit 4 of the modem status register.
// - The transmit pin is high during reset and when idle; disabling the transmitter stops new characters but lets one in progress finish.
// - In loop-back the transmit pin is idle, the receive pin is ignored and tx feeds rx inside.
// - Characters are sent with a start bit before and stop bits after the data; rx strips them.
// - With parity on, tx appends a parity bit and rx checks it to flag errors.
// - Sixteen-entry byte buffers sit in both directions between the bus and the shifters.
// - Four selectable receive fill thresholds each raise a receive-data interrupt when reached.
// - Modem control bit 3 enables the interrupt output and drives user output low; clear floats it.
`timescale 1ns/10ps
`default_nettype none

module ump_line_chan
  import ump_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = BAUD_DIV_DEF,
  parameter int          DEPTH    = FIFO_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        chanSelN,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [7:0]       rdData,
  input  wire logic        rxdIn,
  output logic             txdOut,
  input  wire logic        ctsInN,
  input  wire logic        dsrInN,
  input  wire logic        carrierSenseInN,
  input  wire logic        bellSignalInN,
  output logic             termReadyOutN,
  output logic             sendRequestOutN,
  output logic             userOutputTwoN,
  output logic             irqOutA,
  output logic             irqOeN
);

  localparam int CW = $clog2(DEPTH+1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ump_tx_t     txState;
    logic [15:0] txCnt;
    logic [3:0]  txLeft;
    logic [11:0] txShift;
    logic        txPin;
    logic        txLine;
    ump_rx_t     rxState;
    logic [15:0] rxCnt;
    logic [3:0]  rxLeft;
    logic [9:0]  rxShift;
    logic        rxPush;
    logic [7:0]  rxByte;
    logic [7:0]  intEn;
    logic [7:0]  lineCtrl;
    logic [7:0]  modemCtrl;
    logic [7:0]  fifoCtrl;
    logic [3:0]  intSts;
    logic        overrun;
    logic        parErr;
    logic        frameErr;
    logic [4:0]  pinMeta;
    logic [4:0]  pinSync;
    logic        bellLast;
    logic        trigLast;
    logic        irq;
    logic [7:0]  rdData;
  } ump_chan_state_t;

  localparam ump_chan_state_t ST_RESET = '{
    txState:   TX_IDLE,
    txCnt:     16'h0000,
    txLeft:    4'h0,
    txShift:   12'hfff,
    txPin:     1'b1,
    txLine:    1'b1,
    rxState:   RX_IDLE,
    rxCnt:     16'h0000,
    rxLeft:    4'h0,
    rxShift:   10'h000,
    rxPush:    1'b0,
    rxByte:    8'h00,
    intEn:     INT_EN_RST,
    lineCtrl:  LINE_CTRL_RST,
    modemCtrl: MODEM_CTRL_RST,
    fifoCtrl:  FIFO_CTRL_RST,
    intSts:    4'h0,
    overrun:   1'b0,
    parErr:    1'b0,
    frameErr:  1'b0,
    pinMeta:   5'h1f,
    pinSync:   5'h1f,
    bellLast:  1'b1,
    trigLast:  1'b0,
    irq:       1'b0,
    rdData:    8'h00
  };

  ump_chan_state_t st_reg;
  ump_chan_state_t st_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic parOf(input logic [7:0] d, input logic even);
    parOf = even ? (^d) : ~(^d);
  endfunction

  function automatic logic [4:0] trigLevel(input logic [1:0] sel);
    unique case (sel)
      2'b00:   trigLevel = TRIG_LVL0;
      2'b01:   trigLevel = TRIG_LVL1;
      2'b10:   trigLevel = TRIG_LVL2;
      default: trigLevel = TRIG_LVL3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic          selWr;
  logic          selRd;
  logic          txInValid;
  logic          txInReady;
  logic          txOutValid;
  logic          txOutReady;
  logic [7:0]    txOutData;
  logic [CW-1:0] txFill;
  logic          rxInReady;
  logic          rxOutValid;
  logic          rxOutReady;
  logic [7:0]    rxOutData;
  logic [CW-1:0] rxFill;
  logic          loopOn;
  logic          parEn;
  logic          rxSrc;

  assign selWr      = wrStb && !chanSelN;
  assign selRd      = rdStb && !chanSelN;
  assign txInValid  = selWr && (addr == OFF_DATA);
  assign rxOutReady = selRd && (addr == OFF_DATA);
  assign loopOn     = st_reg.modemCtrl[MC_LOOP];
  assign parEn      = st_reg.lineCtrl[LC_PAR_EN];
  assign txOutReady = (st_reg.txState == TX_IDLE) && st_reg.lineCtrl[LC_TX_EN];
  assign rxSrc      = loopOn ? st_reg.txLine : st_reg.pinSync[PIN_RXD];

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  ump_fifo #(.W(DATA_W), .DEPTH(DEPTH)) txFifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .inValid   (txInValid),
    .inReady   (txInReady),
    .inData    (wrData),
    .outValid  (txOutValid),
    .outReady  (txOutReady),
    .outData   (txOutData),
    .fillCount (txFill)
  );

  ump_fifo #(.W(DATA_W), .DEPTH(DEPTH)) rxFifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .inValid   (st_reg.rxPush),
    .inReady   (rxInReady),
    .inData    (st_reg.rxByte),
    .outValid  (rxOutValid),
    .outReady  (rxOutReady),
    .outData   (rxOutData),
    .fillCount (rxFill)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [3:0] setSts;
  logic [3:0] clrSts;
  logic [9:0] rxNewShift;
  logic [7:0] rxData;
  logic       trigHit;
  logic       lineErrEvt;
  logic [1:0] errEvt;

  always_comb begin
    st_next    = st_reg;
    setSts     = 4'h0;
    clrSts     = 4'h0;
    rxNewShift = {rxSrc, st_reg.rxShift[9:1]};
    rxData     = parEn ? rxNewShift[7:0] : rxNewShift[8:1];
    lineErrEvt = 1'b0;
    errEvt     = 2'b00;
    trigHit    = (32'(rxFill) >= 32'(trigLevel(st_reg.fifoCtrl[FC_TRIG_LO +: 2])));
    st_next.rxPush = 1'b0;
    // pin synchronisers
    st_next.pinMeta = {bellSignalInN, carrierSenseInN, dsrInN, ctsInN, rxdIn};
    st_next.pinSync = st_reg.pinMeta;
    st_next.bellLast = st_reg.pinSync[PIN_RI];
    if (st_reg.pinSync[PIN_RI] && !st_reg.bellLast) begin
      setSts[IS_MODEM] = 1'b1;
    end
    // transmitter
    unique case (st_reg.txState)
      TX_IDLE: begin
        if (txOutValid && txOutReady) begin
          st_next.txState = TX_SHIFT;
          st_next.txCnt   = BAUD_DIV - 16'h0001;
          st_next.txShift = {2'b11,
                             parEn ? parOf(txOutData, st_reg.lineCtrl[LC_PAR_EVEN]) : 1'b1,
                             txOutData, 1'b0};
          st_next.txLeft  = DATA_BITS + 4'h2 + {3'h0, parEn}
                            + {3'h0, st_reg.lineCtrl[LC_STOP2]};
        end
      end
      TX_SHIFT: begin
        if (st_reg.txCnt == 16'h0000) begin
          st_next.txCnt   = BAUD_DIV - 16'h0001;
          st_next.txShift = {1'b1, st_reg.txShift[11:1]};
          st_next.txLeft  = st_reg.txLeft - 4'h1;
          if (st_reg.txLeft == 4'h1) begin
            st_next.txState = TX_IDLE;
            if (!txOutValid) begin
              setSts[IS_TX_EMPTY] = 1'b1;
            end
          end
        end else begin
          st_next.txCnt = st_reg.txCnt - 16'h0001;
        end
      end
      default: st_next.txState = TX_IDLE;
    endcase
    st_next.txLine = (st_next.txState == TX_SHIFT) ? st_next.txShift[0] : 1'b1;
    st_next.txPin  = st_next.txLine || st_next.modemCtrl[MC_LOOP];
    // receiver
    unique case (st_reg.rxState)
      RX_IDLE: begin
        if (!rxSrc) begin
          st_next.rxState = RX_START;
          st_next.rxCnt   = {1'b0, BAUD_DIV[15:1]};
        end
      end
      RX_START: begin
        if (st_reg.rxCnt == 16'h0000) begin
          if (!rxSrc) begin
            st_next.rxState = RX_DATA;
            st_next.rxCnt   = BAUD_DIV - 16'h0001;
            st_next.rxLeft  = DATA_BITS + 4'h1 + {3'h0, parEn};
          end else begin
            st_next.rxState = RX_IDLE;
          end
        end else begin
          st_next.rxCnt = st_reg.rxCnt - 16'h0001;
        end
      end
      RX_DATA: begin
        if (st_reg.rxCnt == 16'h0000) begin
          st_next.rxCnt   = BAUD_DIV - 16'h0001;
          st_next.rxShift = rxNewShift;
          st_next.rxLeft  = st_reg.rxLeft - 4'h1;
          if (st_reg.rxLeft == 4'h1) begin
            st_next.rxState = RX_IDLE;
            st_next.rxPush  = 1'b1;
            st_next.rxByte  = rxData;
            if (parEn && (parOf(rxData, st_reg.lineCtrl[LC_PAR_EVEN]) != rxNewShift[8])) begin
              errEvt[0]  = 1'b1;
              lineErrEvt = 1'b1;
            end
            if (!rxNewShift[9]) begin
              errEvt[1]  = 1'b1;
              lineErrEvt = 1'b1;
            end
          end
        end else begin
          st_next.rxCnt = st_reg.rxCnt - 16'h0001;
        end
      end
      default: st_next.rxState = RX_IDLE;
    endcase
    if (st_reg.rxPush && !rxInReady) begin
      st_next.overrun = 1'b1;
      lineErrEvt      = 1'b1;
    end
    if (lineErrEvt) begin
      setSts[IS_LINE_ERR] = 1'b1;
    end
    // receive threshold event
    st_next.trigLast = trigHit;
    if (trigHit && !st_reg.trigLast) begin
      setSts[IS_RX_TRIG] = 1'b1;
    end
    // register writes
    if (selWr) begin
      unique case (addr)
        OFF_INT_EN:     st_next.intEn     = wrData;
        OFF_FIFO_CTRL:  st_next.fifoCtrl  = wrData;
        OFF_LINE_CTRL:  st_next.lineCtrl  = wrData;
        OFF_MODEM_CTRL: st_next.modemCtrl = wrData;
        OFF_INT_CLR:    clrSts            = wrData[3:0];
        default:        clrSts            = 4'h0;
      endcase
    end
    // register reads, data one cycle later
    st_next.rdData = 8'h00;
    if (selRd) begin
      unique case (addr)
        OFF_DATA:    st_next.rdData = rxOutValid ? rxOutData : 8'h00;
        OFF_INT_EN:  st_next.rdData = st_reg.intEn;
        OFF_INT_STS: st_next.rdData = {4'h0, st_reg.intSts};
        OFF_LINE_CTRL:  st_next.rdData = st_reg.lineCtrl;
        OFF_MODEM_CTRL: st_next.rdData = st_reg.modemCtrl;
        OFF_LINE_STS: begin
          st_next.rdData[LS_RX_AVAIL] = rxOutValid;
          st_next.rdData[LS_OVERRUN]  = st_reg.overrun;
          st_next.rdData[LS_PARITY]   = st_reg.parErr;
          st_next.rdData[LS_FRAMING]  = st_reg.frameErr;
          st_next.rdData[LS_TX_ROOM]  = txInReady;
          st_next.rdData[LS_TX_IDLE]  = !txOutValid && (st_reg.txState == TX_IDLE);
          st_next.overrun  = st_reg.rxPush && !rxInReady;
          {st_next.frameErr, st_next.parErr} = 2'b00;
        end
        OFF_MODEM_STS: begin
          st_next.rdData[MS_CTS]     = !st_reg.pinSync[PIN_CTS];
          st_next.rdData[MS_DSR]     = !st_reg.pinSync[PIN_DSR];
          st_next.rdData[MS_RING]    = !st_reg.pinSync[PIN_RI];
          st_next.rdData[MS_CARRIER] = !st_reg.pinSync[PIN_CD];
        end
        default: st_next.rdData = 8'h00;
      endcase
    end
    // sticky status, set wins over clear
    {st_next.frameErr, st_next.parErr} = {st_next.frameErr, st_next.parErr} | errEvt;
    st_next.intSts = (st_reg.intSts & ~clrSts) | setSts;
    st_next.irq    = |(st_next.intSts & st_next.intEn[3:0]);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData          = st_reg.rdData;
  assign txdOut          = st_reg.txPin;
  assign termReadyOutN   = !st_reg.modemCtrl[MC_TERM_READY];
  assign sendRequestOutN = !st_reg.modemCtrl[MC_SEND_REQ];
  assign userOutputTwoN  = !st_reg.modemCtrl[MC_INT_OUT];
  assign irqOeN          = !st_reg.modemCtrl[MC_INT_OUT];
  assign irqOutA         = st_reg.irq && st_reg.modemCtrl[MC_INT_OUT];

endmodule

`default_nettype wire

//--- ump_line_chan_chk.sv
// assertion checker for one serial line channel
`timescale 1ns/10ps
`default_nettype none

module ump_line_chan_chk (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       chanSelN,
  input wire logic [2:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  input wire logic       txdOut,
  input wire logic       ctsInN,
  input wire logic       dsrInN,
  input wire logic       carrierSenseInN,
  input wire logic       bellSignalInN,
  input wire logic       termReadyOutN,
  input wire logic       sendRequestOutN,
  input wire logic       userOutputTwoN,
  input wire logic       irqOutA,
  input wire logic       irqOeN
);
  logic       mcrW;
  logic       rdTaken;
  logic [3:0] pinsNow;
  logic       loop_reg;
  logic [2:0] calm_reg;
  assign mcrW    = wrStb && !chanSelN && addr == 3'h4;
  assign rdTaken = rdStb && !chanSelN;
  assign pinsNow = {carrierSenseInN, bellSignalInN, dsrInN, ctsInN};
  // ----------------------------------------
  // loop mode and modem pin quiet time
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      loop_reg <= 1'b0;
      calm_reg <= 3'h0;
    end else begin
      if (mcrW) begin
        loop_reg <= wrData[4];
      end
      if ($changed(pinsNow)) begin
        calm_reg <= 3'h0;
      end else if (calm_reg != 3'h4) begin
        calm_reg <= calm_reg + 3'h1;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // pin and bus relations
  // ----------------------------------------
  rst_idle_a: assert property ($rose(rstn) |-> txdOut && termReadyOutN
    && sendRequestOutN && userOutputTwoN && irqOeN && !irqOutA) else $error("pins not idle");
  term_ready_a: assert property (mcrW |-> ##2 termReadyOutN == !$past(wrData[0], 2))
    else $error("term ready wrong");
  send_req_a: assert property (mcrW |-> ##2 sendRequestOutN == !$past(wrData[1], 2))
    else $error("send request wrong");
  user_out_a: assert property (mcrW |-> ##2 userOutputTwoN == !$past(wrData[3], 2)
    && irqOeN == !$past(wrData[3], 2)) else $error("user out wrong");
  irq_gate_a: assert property (irqOutA |-> !irqOeN) else $error("irq floating");
  loop_idle_a: assert property (loop_reg && $past(loop_reg, 2) |-> txdOut)
    else $error("txd moves in loop");
  rd_quiet_a: assert property (!$past(rdTaken) |-> rdData == 8'h00)
    else $error("read data not quiet");
  modem_sts_a: assert property (rdTaken && addr == 3'h6 && calm_reg == 3'h4
    |=> rdData[7:4] == ~$past(pinsNow)) else $error("modem status wrong");
  ring_c: cover property ($rose(bellSignalInN) ##[1:8] irqOutA);
  loop_c: cover property (loop_reg && wrStb && addr == 3'h0);
  sts_c: cover property (rdTaken && addr == 3'h6 && calm_reg == 3'h4);
endmodule

bind ump_line_chan ump_line_chan_chk chk (.mclk, .rstn, .chanSelN, .addr, .wrData, .wrStb,
  .rdStb, .rdData, .txdOut, .ctsInN, .dsrInN, .carrierSenseInN, .bellSignalInN,
  .termReadyOutN, .sendRequestOutN, .userOutputTwoN, .irqOutA, .irqOeN);

`default_nettype wire

//--- ump_modem_model.sv
// far serial device: frames on rxd, captures frames on txd
`timescale 1ns/10ps
`default_nettype none

module ump_modem_model #(
  parameter int BD = 4
) (
  input  wire logic mclk,
  input  wire logic txdOut,
  output var logic  rxdIn,
  output var logic  ctsInN,
  output var logic  dsrInN,
  output var logic  carrierSenseInN,
  output var logic  bellSignalInN
);
  logic [8:0] seen[$];
  logic [8:0] cap;
  initial begin
    rxdIn = 1'b1;
    {carrierSenseInN, bellSignalInN, dsrInN, ctsInN} = 4'hf;
  end
  // pins in order carrier, ring, dsr, cts
  task automatic setPins(input logic [3:0] p);
    {carrierSenseInN, bellSignalInN, dsrInN, ctsInN} <= p;
  endtask
  // start, data lsb first, extra bit, stop
  task automatic sendChar(input logic [7:0] d, input logic ex);
    logic [10:0] fr;
    fr = {1'b1, ex, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxdIn <= fr[i];
      repeat (BD) @(posedge mclk);
    end
  endtask
  // data bits and the bit after them, mid-bit samples
  always begin
    @(negedge txdOut);
    repeat (BD / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BD) @(posedge mclk);
      cap[i] = txdOut;
    end
    seen.push_back(cap);
  end
endmodule

`default_nettype wire

//--- ump_line_chan_tb.sv
// bench for one serial line channel and its modem model
`timescale 1ns/10ps
`default_nettype none

module ump_line_chan_tb
  import ump_pkg::*;
;
  localparam int BD = 4;
  logic mclk = 1'b0, rstn = 1'b0, chanSelN = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rdSeen = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h00, rdData, b;
  logic txdOut, rxdIn, ctsInN, dsrInN, carrierSenseInN, bellSignalInN;
  logic termReadyOutN, sendRequestOutN, userOutputTwoN, irqOutA, irqOeN;
  logic [15:0] ex;
  logic [15:0] expQ[$];
  logic [8:0] txQ[$];
  logic [7:0] dq[$];
  logic [7:0] lcTab[4] = '{8'h44, 8'h40, 8'h48, 8'h58};
  int lv[4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, TRIG_LVL3};
  int fails = 0, compares = 0;
  always #10 mclk = ~mclk;
  ump_line_chan #(.BAUD_DIV(16'h0004)) uut (.mclk, .rstn, .chanSelN, .addr, .wrData, .wrStb,
    .rdStb, .rdData, .rxdIn, .txdOut, .ctsInN, .dsrInN, .carrierSenseInN, .bellSignalInN,
    .termReadyOutN, .sendRequestOutN, .userOutputTwoN, .irqOutA, .irqOeN);
  ump_modem_model #(.BD(BD)) pm (.mclk, .txdOut, .rxdIn, .ctsInN, .dsrInN, .carrierSenseInN,
    .bellSignalInN);
  // ----------------------------------------
  // bus tasks and compares
  // ----------------------------------------
  task automatic check(input string n, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    expQ.push_back({m, e & m});
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pins(input logic [4:0] e);
    #1;
    check("pins", {4'h0, e},
      {4'h0, termReadyOutN, sendRequestOutN, userOutputTwoN, irqOeN, txdOut});
  endtask
  task automatic give_verdict();
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    rdSeen <= rdStb;
    if (rdSeen) begin
      ex = expQ.pop_front();
      check("rdData", {1'b0, ex[7:0]}, {1'b0, rdData & ex[15:8]});
    end
    if (pm.seen.size() > 0) check("txFrame", txQ.pop_front(), pm.seen.pop_front());
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    give_verdict();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(37));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    chanSelN <= 1'b0;
    @(posedge mclk);
    pins(5'h1f);
    for (int i = 0; i < 8; i++) begin
      b = {4'h0, i[2], 1'b0, i[1:0]};
      wr(3'h4, b);
      repeat (2) @(posedge mclk);
      pins({~b[0], ~b[1], ~b[3], ~b[3], 1'b1});
      rd(3'h4, 8'h1b, b);
    end
    wr(3'h4, 8'h00);
    chanSelN <= 1'b1;
    wr(3'h4, 8'h0b);
    rd(3'h4, 8'hff, 8'h00);
    chanSelN <= 1'b0;
    pins(5'h1f);
    repeat (4) begin
      b = 8'($urandom);
      pm.setPins(b[3:0]);
      repeat (6) @(posedge mclk);
      rd(3'h6, 8'hf0, {~b[3:0], 4'h0});
    end
    pm.setPins(4'hf);
    repeat (4) @(posedge mclk);
    wr(3'h4, 8'h08);
    for (int e = 1; e >= 0; e--) begin
      wr(3'h1, {5'h00, e[0], 2'h0});
      wr(3'h7, 8'h0f);
      pm.setPins(4'hb);
      repeat (5) @(posedge mclk);
      pm.setPins(4'hf);
      repeat (5) @(posedge mclk);
      #1;
      check("irqOutA", {8'h0, e[0]}, {8'h0, irqOutA});
      rd(3'h2, 8'h04, 8'h04);
      wr(3'h7, 8'h0f);
      repeat (2) @(posedge mclk);
      #1;
      check("irqOutA", 9'h0, {8'h0, irqOutA});
    end
    for (int k = 0; k < 4; k++) begin
      wr(3'h3, lcTab[k]);
      b = 8'($urandom);
      txQ.push_back({lcTab[k][3] ? (lcTab[k][4] ? ^b : ~^b) : 1'b1, b});
      wr(3'h0, b);
      repeat (12 * BD) @(posedge mclk);
    end
    b = 8'($urandom);
    pm.sendChar(b, ~^b);
    repeat (4) @(posedge mclk);
    rd(3'h5, 8'h05, 8'h05);
    rd(3'h0, 8'hff, b);
    pm.sendChar(b, ^b);
    repeat (4) @(posedge mclk);
    rd(3'h5, 8'h05, 8'h01);
    rd(3'h0, 8'hff, b);
    wr(3'h4, 8'h10);
    fork
      wr(3'h0, b);
      pm.sendChar(~b, 1'b0);
    join
    repeat (8) @(posedge mclk);
    rd(3'h0, 8'hff, b);
    rd(3'h5, 8'h01, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h40);
    for (int t = 0; t < 4; t++) begin
      wr(3'h2, {t[1:0], 6'h00});
      wr(3'h7, 8'h01);
      for (int j = 1; j <= lv[t]; j++) begin
        if (j == lv[t]) rd(3'h2, 8'h01, 8'h00);
        b = 8'($urandom);
        dq.push_back(b);
        pm.sendChar(b, 1'b1);
        repeat (4) @(posedge mclk);
      end
      rd(3'h2, 8'h01, 8'h01);
      while (dq.size() > 0) rd(3'h0, 8'hff, dq.pop_front());
    end
    repeat (17) begin
      b = 8'($urandom);
      dq.push_back(b);
      pm.sendChar(b, 1'b1);
    end
    repeat (4) @(posedge mclk);
    void'(dq.pop_back());
    rd(3'h5, 8'h03, 8'h03);
    while (dq.size() > 0) rd(3'h0, 8'hff, dq.pop_front());
    rd(3'h5, 8'h01, 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
